// file: hw/reset_seq_defs.vh
// constants for the octal monitor reset sequencer
// assumes a 100 MHz core clock and a 32-bit classic wishbone slave port
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH

// clock rate in hz, and the same in khz for overflow-safe products
`define CLK_HZ            100000000
`define CLK_KHZ           100000
// timing capacitance per second of timeout, in nF
`define TMR_NF_PER_S      115
// pF per nF
`define PF_PER_NF         1000
// default timing capacitance in pF (11500 pF gives 100 ms)
`define TMR_CAP_PF_DEF    11500

// register byte offsets
`define ADR_CTRL          8'h00
`define ADR_TIMEOUT       8'h04
`define ADR_STATUS        8'h08

// control register fields
`define CTRL_BYPASS       0
`define CTRL_W            1

// status register fields
`define ST_STATE_LO       0
`define ST_STATE_HI       1
`define ST_FAULT          2
`define ST_LOCKOUT        3
`define ST_DISABLE        4
`define ST_RST_OUT        5
`define ST_FAULT_SEEN     6
`define ST_UV_LO          8
`define ST_UV_HI          15

// polarity selector codes for inputs seven and eight
`define POL_BOTH_POS      2'h0
`define POL_SEVEN_POS     2'h1
`define POL_BOTH_NEG      2'h2

// sequencer states
`define S_LOCK            2'h0
`define S_HOLD            2'h1
`define S_TIME            2'h2
`define S_RUN             2'h3

// hold causes, highest priority first
`define CS_NONE           2'h0
`define CS_LOCK           2'h1
`define CS_OFF            2'h2
`define CS_FAULT          2'h3

`define ZERO32            32'h00000000
`define ONE32             32'h00000001

`endif

// file: hw/octal_monitor_reset_sequencer.v
// reset sequencer for an eight-input supply monitor with a wishbone register port
// assumes comparator results, lockout, disable, strap and selector are synchronous
// to core_clk; rst is synchronous and active high
// the timeout length starts from the parameter and may be rewritten over the bus
// the reset pair is driven as plain levels; open-drain drive is left to the pads
// the bus is a classic single-cycle slave that answers one cycle after a request
//
// Summary of operation
// R1 - Any flagged undervoltage input asserts both reset outputs at once.
// R2 - When every input is valid again the delay timer starts while the resets stay asserted.
// R3 - When the timer expires with all inputs valid both resets are released.
// R4 - A fault during the delay clears the timer, which restarts from zero once all inputs are valid.
// R5 - The timeout is configurable, derived from timing capacitance at 115 nF per second.
// R6 - With the bypass strap active the resets release as soon as all inputs are valid.
// R7 - While supply lockout holds both resets stay asserted.
// R8 - Leaving lockout with disable inactive runs the normal timed release.
// R9 - While disable is high both resets stay deasserted whatever the input faults.
// R10 - With disable high lockout still asserts the resets, released at once when it clears.
// R11 - The disable input is taken as inactive when low, its unconnected default.
// R12 - A three-way selector sets the polarity of inputs seven and eight.
// R13 - The eight undervoltage flags are ORed and synchronised before the sequencer uses them.
//
// Chosen here: the placing of the registers and register access over Wishbone.
`include "reset_seq_defs.vh"

module octal_monitor_reset_sequencer #(
    parameter [31:0] TMR_CAP_PF     = `TMR_CAP_PF_DEF,
    parameter [31:0] TIMEOUT_CYCLES = TMR_CAP_PF * `CLK_KHZ / `TMR_NF_PER_S
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [7:0]  monitored_input,
    input  wire [1:0]  polarity_sel,
    input  wire        supply_lockout,
    input  wire        output_disable_in,
    input  wire        timeout_setting_pin,
    output reg         rst_out,
    output reg         rst_out_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o
);

    // sequencer states and hold causes
    localparam [1:0] LOCK        = `S_LOCK;
    localparam [1:0] HOLD        = `S_HOLD;
    localparam [1:0] TIMING      = `S_TIME;
    localparam [1:0] RUN         = `S_RUN;
    localparam [1:0] CAUSE_NONE  = `CS_NONE;
    localparam [1:0] CAUSE_LOCK  = `CS_LOCK;
    localparam [1:0] CAUSE_OFF   = `CS_OFF;
    localparam [1:0] CAUSE_FAULT = `CS_FAULT;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [31:0] count;
    reg  [31:0] next_count;
    reg         next_assert;
    reg         fault_meta;
    reg         fault_sync;
    reg         bypass_soft;
    reg  [31:0] timeout_reg;
    reg         fault_seen;
    reg  [7:0]  uv_flag;
    reg  [31:0] next_timeout;
    reg  [31:0] rd_data;
    wire        bus_req;
    wire        bus_wr;
    wire        bypass;
    reg         hit_ctrl;
    reg         hit_timeout;
    reg         hit_status;
    reg         neg_six;
    reg         neg_seven;
    reg  [1:0]  cause;
    wire        any_uv;
    wire        wr_ctrl;
    wire        wr_timeout;
    wire        clear_seen;
    wire        rd_req;
    wire        timer_done;
    wire [31:0] count_inc;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = bus_req & wb_we_i;
    // R6 strap or soft bypass
    assign bypass  = timeout_setting_pin | bypass_soft;

    assign wr_ctrl    = bus_wr & hit_ctrl & wb_sel_i[0];
    assign wr_timeout = bus_wr & hit_timeout;
    // sticky flag clear is write-one on the low lane
    assign clear_seen = bus_wr & hit_status & wb_sel_i[0] & wb_dat_i[`ST_FAULT_SEEN];
    assign rd_req     = bus_req & ~wb_we_i;
    // R3 R5 expiry against the programmed length
    assign count_inc  = count + `ONE32;
    assign timer_done = (count_inc >= timeout_reg);

    // register decode
    always @* begin
        hit_ctrl    = 1'b0;
        hit_timeout = 1'b0;
        hit_status  = 1'b0;
        if (wb_adr_i == `ADR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (wb_adr_i == `ADR_TIMEOUT) begin
            hit_timeout = 1'b1;
        end else if (wb_adr_i == `ADR_STATUS) begin
            hit_status = 1'b1;
        end
    end

    // R12 selector picks which of inputs seven and eight are negative
    always @* begin
        neg_six   = 1'b0;
        neg_seven = 1'b0;
        if (polarity_sel == `POL_BOTH_POS) begin
            neg_six   = 1'b0;
            neg_seven = 1'b0;
        end else if (polarity_sel == `POL_SEVEN_POS) begin
            neg_six   = 1'b0;
            neg_seven = 1'b1;
        end else if (polarity_sel == `POL_BOTH_NEG) begin
            neg_six   = 1'b1;
            neg_seven = 1'b1;
        end else begin
            // open selector code behaves as the mixed setting
            neg_six   = 1'b0;
            neg_seven = 1'b1;
        end
    end

    // high input means above threshold on a positive input
    always @* begin
        uv_flag[0] = ~monitored_input[0];
        uv_flag[1] = ~monitored_input[1];
        uv_flag[2] = ~monitored_input[2];
        uv_flag[3] = ~monitored_input[3];
        uv_flag[4] = ~monitored_input[4];
        uv_flag[5] = ~monitored_input[5];
        uv_flag[6] = monitored_input[6] ^ ~neg_six;
        uv_flag[7] = monitored_input[7] ^ ~neg_seven;
    end

    // R13 or of flags, two-stage sync; reset reads as a fault
    assign any_uv = |uv_flag;

    always @(posedge core_clk) begin
        if (rst) begin
            fault_meta <= 1'b1;
        end else begin
            fault_meta <= any_uv;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            fault_sync <= 1'b1;
        end else begin
            fault_sync <= fault_meta;
        end
    end

    // priority of causes: lockout over disable over fault
    always @* begin
        cause = CAUSE_NONE;
        if (supply_lockout) begin
            cause = CAUSE_LOCK;
        end else if (output_disable_in) begin
            cause = CAUSE_OFF;
        end else if (fault_sync) begin
            cause = CAUSE_FAULT;
        end
    end

    always @* begin
        next_state  = state;
        next_count  = count;
        next_assert = 1'b1;
        case (cause)
            CAUSE_LOCK: begin
                // R7 lockout holds reset
                next_state = LOCK;
                next_count = `ZERO32;
            end
            CAUSE_OFF: begin
                // R9 R10 R11 disabled outputs released, no timeout
                next_state  = RUN;
                next_count  = `ZERO32;
                next_assert = 1'b0;
            end
            CAUSE_FAULT: begin
                // R1 R4 fault asserts and clears timer
                next_state = HOLD;
                next_count = `ZERO32;
            end
            default: begin
                case (state)
                    LOCK: begin
                        // R8 leaving lockout runs the timed release; R6 bypass
                        if (bypass) begin
                            next_state  = RUN;
                            next_assert = 1'b0;
                        end else begin
                            next_state = TIMING;
                            next_count = `ZERO32;
                        end
                    end
                    HOLD: begin
                        // R2 start delay; R6 bypass
                        if (bypass) begin
                            next_state  = RUN;
                            next_assert = 1'b0;
                        end else begin
                            next_state = TIMING;
                            next_count = `ZERO32;
                        end
                    end
                    TIMING: begin
                        // R3 R5 release on expiry
                        if (bypass || timer_done) begin
                            next_state  = RUN;
                            next_assert = 1'b0;
                        end else begin
                            next_count = count_inc;
                        end
                    end
                    default: begin
                        // released until a new cause appears
                        next_assert = 1'b0;
                    end
                endcase
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            state <= LOCK;
            count <= `ZERO32;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // R1 R3 complementary pair, both registered
    always @(posedge core_clk) begin
        if (rst) begin
            rst_out   <= 1'b1;
            rst_out_n <= 1'b0;
        end else begin
            rst_out   <= next_assert;
            rst_out_n <= ~next_assert;
        end
    end

    // byte-lane merge for the timeout register
    always @* begin
        next_timeout = timeout_reg;
        if (wb_sel_i[0]) begin
            next_timeout[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            next_timeout[15:8] = wb_dat_i[15:8];
        end
        if (wb_sel_i[2]) begin
            next_timeout[23:16] = wb_dat_i[23:16];
        end
        if (wb_sel_i[3]) begin
            next_timeout[31:24] = wb_dat_i[31:24];
        end
    end

    always @* begin
        rd_data = `ZERO32;
        if (wb_adr_i == `ADR_CTRL) begin
            rd_data[`CTRL_BYPASS] = bypass_soft;
        end else if (wb_adr_i == `ADR_TIMEOUT) begin
            rd_data = timeout_reg;
        end else if (wb_adr_i == `ADR_STATUS) begin
            rd_data[`ST_STATE_HI:`ST_STATE_LO] = state;
            rd_data[`ST_FAULT]                 = fault_sync;
            rd_data[`ST_LOCKOUT]               = supply_lockout;
            rd_data[`ST_DISABLE]               = output_disable_in;
            rd_data[`ST_RST_OUT]               = rst_out;
            rd_data[`ST_FAULT_SEEN]            = fault_seen;
            rd_data[`ST_UV_HI:`ST_UV_LO]       = uv_flag;
        end
    end

    // one-cycle ack, never back to back
    always @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // read data held until the next read
    always @(posedge core_clk) begin
        if (rst) begin
            wb_dat_o <= `ZERO32;
        end else if (rd_req) begin
            wb_dat_o <= rd_data;
        end
    end

    // R6 soft bypass in the low control bit
    always @(posedge core_clk) begin
        if (rst) begin
            bypass_soft <= 1'b0;
        end else if (wr_ctrl) begin
            bypass_soft <= wb_dat_i[`CTRL_BYPASS];
        end
    end

    // R5 programmed timeout length
    always @(posedge core_clk) begin
        if (rst) begin
            timeout_reg <= TIMEOUT_CYCLES;
        end else if (wr_timeout) begin
            timeout_reg <= next_timeout;
        end
    end

    // sticky fault: set wins over write-one clear
    always @(posedge core_clk) begin
        if (rst) begin
            fault_seen <= 1'b0;
        end else if (fault_sync) begin
            fault_seen <= 1'b1;
        end else if (clear_seen) begin
            fault_seen <= 1'b0;
        end
    end

endmodule // octal_monitor_reset_sequencer

// file: dv/seq_asserts.sv
// assertions on the ports of the reset sequencer
// assumes one clock, rst synchronous active high
module seq_asserts #(
    parameter [31:0] TIMEOUT_CYCLES = 32'h00000014
) (
    input logic       core_clk,
    input logic       rst,
    input logic [7:0] monitored_input,
    input logic [1:0] polarity_sel,
    input logic       supply_lockout,
    input logic       output_disable_in,
    input logic       timeout_setting_pin,
    input logic       rst_out,
    input logic       rst_out_n,
    input logic       wb_cyc_i,
    input logic       wb_stb_i,
    input logic       wb_ack_o,
    input logic        wb_we_i,
    input logic [7:0]  wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic uv;
    int   cnt;
    logic soft_byp;
    // shadow of the soft bypass bit, seen from the bus
    always @(posedge core_clk) begin
        if (rst)
            soft_byp <= 1'b0;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
            soft_byp <= wb_dat_i[0];
    end
    assign uv = ~&monitored_input[5:0]
              | (polarity_sel == 2'h2 ? monitored_input[6] : ~monitored_input[6])
              | (polarity_sel == 2'h0 ? ~monitored_input[7] : monitored_input[7]);
    // clean cycles since last fault or lockout
    always @(posedge core_clk) begin
        if (rst || uv || supply_lockout)
            cnt <= 0;
        else if (cnt < TIMEOUT_CYCLES + 8)
            cnt <= cnt + 1;
    end
    pair_ok_a: assert property (rst_out_n == !rst_out)
        else $error("reset pair not complementary");
    lock_hold_a: assert property (supply_lockout |=> rst_out)
        else $error("lockout left reset released");
    dis_free_a: assert property (output_disable_in && !supply_lockout |=> !rst_out)
        else $error("disable did not release reset");
    fault_rst_a: assert property ((uv && !output_disable_in && !supply_lockout) [*3] |=> rst_out)
        else $error("fault did not assert reset");
    min_hold_a: assert property ($fell(rst_out) && !$past(output_disable_in)
        && !timeout_setting_pin && !soft_byp |-> cnt >= TIMEOUT_CYCLES)
        else $error("reset released before timeout");
    max_hold_a: assert property (cnt == TIMEOUT_CYCLES + 8 |-> !rst_out)
        else $error("reset held past timeout");
    bypass_rel_a: assert property (timeout_setting_pin && cnt == 4 |-> !rst_out)
        else $error("bypass did not release reset");
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
endmodule // seq_asserts

bind octal_monitor_reset_sequencer seq_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) seq_asserts_i (
    .core_clk, .rst, .monitored_input, .polarity_sel, .supply_lockout, .output_disable_in,
    .timeout_setting_pin, .rst_out, .rst_out_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i);

// file: dv/held_system.sv
// downstream logic held in reset by the sequencer
// counts each release of the reset pair
module held_system (
    input  logic core_clk,
    input  logic rst,
    input  logic rst_out,
    input  logic rst_out_n,
    output int   starts
);
    logic run_q;
    always @(posedge core_clk) begin
        if (rst) begin
            run_q  <= 1'b0;
            starts <= 0;
        end else begin
            run_q <= !rst_out && rst_out_n;
            if (!rst_out && rst_out_n && !run_q)
                starts <= starts + 1;
        end
    end
endmodule // held_system

// file: dv/tb_octal_monitor_reset_sequencer.sv
// self-checking bench for the reset sequencer
// drives all inputs and the register port on rising edges
`include "reset_seq_defs.vh"
module tb_octal_monitor_reset_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 20;
    logic        core_clk, rst, lock, dis, strap, cyc, stb, we, ack, ro, ron;
    logic [7:0]  mi, adr;
    logic [1:0]  pol, g;
    logic [3:0]  sel;
    logic [31:0] wd, rd, dout, r;
    int          fails = 0, n_compared = 0, cyc_n = 0, rel = 0, starts, k;
    octal_monitor_reset_sequencer #(.TIMEOUT_CYCLES(T)) octal_monitor_reset_sequencer_i (
        .core_clk(core_clk), .rst(rst), .monitored_input(mi), .polarity_sel(pol),
        .supply_lockout(lock), .output_disable_in(dis), .timeout_setting_pin(strap),
        .rst_out(ro), .rst_out_n(ron), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dout), .wb_ack_o(ack));
    held_system held_system_i (.core_clk(core_clk), .rst(rst), .rst_out(ro), .rst_out_n(ron),
        .starts(starts));
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 3000) begin
            fails = fails + 1;
            test_done;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] v);
        n_compared++;
        if (v !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, v, e);
        end
    endtask
    task automatic chr(input logic e);
        chk({30'h0, e, !e}, {30'h0, ro, ron});
    endtask
    task automatic rel_chk;
        tick(T - 2);
        chr(1);
        tick(10);
        chr(0);
        rel++;
        chk(rel, starts);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        @(posedge core_clk);
        while (ack !== 1'b1) @(posedge core_clk);
        rd = dout;
        cyc <= 0;
        stb <= 0;
        @(posedge core_clk);
    endtask
    task automatic fin(input string s);
        $display("test %s finished", s);
    endtask
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {pol, lock, dis, strap, cyc, stb, we, adr, wd} = '0;
        mi = 8'hFF;
        sel = 4'hF;
        rst = 1;
        void'($urandom(22));
        tick(12);
        rst <= 0;
        rel_chk;
        fin("power-up");
        k = $urandom_range(5);
        mi[k] <= 0;
        tick(4);
        chr(1);
        mi[k] <= 1;
        tick(T / 2);
        mi[k] <= 0;
        tick(4);
        chr(1);
        mi[k] <= 1;
        rel_chk;
        fin("fault restart");
        for (int p = 0; p < 3; p++) begin
            g = (p == 0) ? 2'h3 : (p == 1) ? 2'h1 : 2'h0;
            pol <= 2'(p);
            mi[7:6] <= g ^ 2'($urandom_range(1, 3));
            tick(4);
            chr(1);
            mi[7:6] <= g;
            rel_chk;
        end
        fin("polarity");
        strap <= 1;
        mi[0] <= 0;
        tick(4);
        chr(1);
        mi[0] <= 1;
        tick(6);
        chr(0);
        rel++;
        strap <= 0;
        lock <= 1;
        tick(2);
        chr(1);
        lock <= 0;
        rel_chk;
        fin("bypass lockout");
        dis <= 1;
        mi[1] <= 0;
        tick(4);
        chr(0);
        lock <= 1;
        tick(2);
        chr(1);
        lock <= 0;
        tick(2);
        chr(0);
        rel++;
        dis <= 0;
        tick(4);
        chr(1);
        mi[1] <= 1;
        rel_chk;
        fin("disable");
        bus(0, `ADR_TIMEOUT, 0);
        chk(T, rd);
        r = $urandom;
        bus(1, `ADR_TIMEOUT, r);
        bus(0, `ADR_TIMEOUT, 0);
        chk(r, rd);
        sel <= 4'h1;
        bus(1, `ADR_TIMEOUT, T);
        sel <= 4'hF;
        bus(0, `ADR_TIMEOUT, 0);
        chk({r[31:8], 8'(T)}, rd);
        bus(1, `ADR_TIMEOUT, T);
        bus(0, 8'h0C, 32'hFFFFFFFF);
        chk(0, rd);
        bus(1, `ADR_CTRL, 1);
        mi[2] <= 0;
        tick(4);
        chr(1);
        mi[2] <= 1;
        tick(6);
        chr(0);
        rel++;
        chk(rel, starts);
        bus(0, `ADR_STATUS, 0);
        chk(32'h43, rd);
        bus(1, `ADR_STATUS, 32'h40);
        bus(1, `ADR_CTRL, 0);
        bus(0, `ADR_STATUS, 0);
        chk(32'h03, rd);
        fin("registers");
        test_done;
    end
endmodule // tb_octal_monitor_reset_sequencer
